// ---- bench/cpu_vector_model.sv ----
// processor model that vectors to pending external interrupts
module cpu_vector_model
    import irq_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic rst_n, // reset, active low
    input wire logic [1:0] ext_req, // external requests
    input wire logic ack_en, // vectoring allowed
    input wire logic slow, // long response
    output logic [1:0] vector_ack // one cycle vector pulse
);
    logic [3:0] cnt_r;
    logic [1:0] ch_r;
    // -------------------------------------------------------------
    // vector sequencer
    // -------------------------------------------------------------
    // take request, vector, then back off
    // the back-off covers the two cycles the request needs to fall
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 4'h0;
            ch_r <= 2'h0;
            vector_ack <= 2'h0;
        end else begin
            vector_ack <= (cnt_r == 4'h4) ? ch_r : 2'h0;
            if (cnt_r != 4'h0) begin
                cnt_r <= cnt_r - 4'h1;
            end else if (ack_en && ext_req != 2'h0) begin
                cnt_r <= slow ? 4'hA : 4'h6;
                ch_r <= ext_req[0] ? 2'h1 : 2'h2;
            end
        end
    end
endmodule // cpu_vector_model

// ---- bench/ext_irq_ctrl_assertions.sv ----
// concurrent checks on the extended interrupt unit ports
module ext_irq_ctrl_assertions
    import irq_pkg::*;
#(
    parameter int NSRC = 8
) (
    input wire logic REF_CLK, // clock
    input wire logic NRST, // reset, active low
    input wire logic [7:0] SFR_ADDR, // address
    input wire logic [7:0] SFR_WDATA, // write data
    input wire logic SFR_WE, // write strobe
    input wire logic SFR_RE, // read strobe
    input wire logic [7:0] SFR_RDATA, // read data
    input wire logic [NSRC-1:0] SRC_REQ, // raw requests
    input wire logic GLOBAL_IRQ_ENABLE, // global enable
    input wire logic [NUM_PINS-1:0] PORT0_IN, // pins
    input wire logic [NUM_EXT-1:0] EXT_VECTOR_ACK, // vector taken
    input wire logic [NSRC-1:0] IRQ_REQ, // gated requests
    input wire logic [NSRC-1:0] IRQ_PRIO, // priorities
    input wire logic [NUM_EXT-1:0] EXT_PENDING, // pending flags
    input wire logic [NUM_EXT-1:0] EXT_REQ // external requests
);
    logic [7:0] en_r, pr_r, cfg_r, s1_r, s2_r;
    logic [1:0] trig_r, lvl, lvl_d_r, edg;
    logic [2:0] live_r;
    // -------------------------------------------------------------
    // shadow of registers and pin sync
    // -------------------------------------------------------------
    // mirror writes so checks never read the design's own state
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            en_r <= RST_ENABLE;
            pr_r <= RST_PRIO;
            cfg_r <= RST_EXT_CFG;
            trig_r <= RST_TRIGGER;
            live_r <= 3'h0;
        end else begin
            if (SFR_WE && SFR_ADDR == ADDR_ENABLE) en_r <= SFR_WDATA;
            if (SFR_WE && SFR_ADDR == ADDR_PRIO) pr_r <= SFR_WDATA;
            if (SFR_WE && SFR_ADDR == ADDR_EXT_CFG) cfg_r <= SFR_WDATA;
            if (SFR_WE && SFR_ADDR == ADDR_TIMER_CTL)
                trig_r <= {SFR_WDATA[2], SFR_WDATA[0]};
            if (live_r != 3'h7) live_r <= live_r + 3'h1;
        end
    end
    // sync flops are unreset here, so checks wait for live_r
    always_ff @(posedge REF_CLK) begin
        s1_r <= PORT0_IN;
        s2_r <= s1_r;
        lvl_d_r <= lvl;
    end
    assign lvl[0] = s2_r[cfg_r[2:0]] == cfg_r[3];
    assign lvl[1] = s2_r[cfg_r[6:4]] == cfg_r[7];
    assign edg = lvl & ~lvl_d_r;
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!NRST);
    property p_req_gate;
        IRQ_REQ == $past(SRC_REQ & en_r[NSRC-1:0] & {NSRC{GLOBAL_IRQ_ENABLE}});
    endproperty
    a_req_gate: assert property (p_req_gate)
        else $error("gated request wrong");
    property p_prio;
        IRQ_PRIO == $past(pr_r[NSRC-1:0]);
    endproperty
    a_prio: assert property (p_prio)
        else $error("priority output wrong");
    property p_ext_req;
        EXT_REQ == $past(EXT_PENDING & {2{GLOBAL_IRQ_ENABLE}});
    endproperty
    a_ext_req: assert property (p_ext_req)
        else $error("external request wrong");
    property p_rd_en;
        SFR_RE && SFR_ADDR == ADDR_ENABLE |=> SFR_RDATA == $past(en_r);
    endproperty
    a_rd_en: assert property (p_rd_en)
        else $error("enable readback wrong");
    property p_rd_pr;
        SFR_RE && SFR_ADDR == ADDR_PRIO |=> SFR_RDATA == $past(pr_r);
    endproperty
    a_rd_pr: assert property (p_rd_pr)
        else $error("priority readback wrong");
    property p_level;
        live_r == 3'h7 |-> (EXT_PENDING & ~$past(trig_r))
            == ($past(lvl) & ~$past(trig_r));
    endproperty
    a_level: assert property (p_level)
        else $error("level pending wrong");
    property p_edge_set;
        live_r == 3'h7 && |(edg & trig_r) && $stable(cfg_r)
            |=> (EXT_PENDING & $past(edg & trig_r)) == $past(edg & trig_r);
    endproperty
    a_edge_set: assert property (p_edge_set)
        else $error("edge pending not set");
    property p_ack_clr;
        live_r == 3'h7 && |(EXT_VECTOR_ACK & trig_r & ~edg) && !SFR_WE
            |=> (EXT_PENDING & $past(EXT_VECTOR_ACK & trig_r & ~edg)) == 2'h0;
    endproperty
    a_ack_clr: assert property (p_ack_clr)
        else $error("pending not cleared by vector");
endmodule // ext_irq_ctrl_assertions

// ---- bench/tb_top.sv ----
// self-checking bench for the extended interrupt unit
module tb_top
    import irq_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        logic [7:0] en;
        logic [7:0] src;
        logic glob;
        logic [7:0] exp;
    } row_t;
    logic clk, nrst, we, re, glob, ack_en, slow;
    logic [7:0] addr, wdata, rdata, src, pins, irq, prio, rd;
    logic [1:0] ack, pend, ereq;
    int miscompares, n_tests;
    row_t rows [9] = '{'{8'h80, 8'h80, 1'b1, 8'h80},
        '{8'h40, 8'hFF, 1'b1, 8'h40}, '{8'h20, 8'h20, 1'b0, 8'h00},
        '{8'h18, 8'h18, 1'b1, 8'h18}, '{8'h04, 8'hFB, 1'b1, 8'h00},
        '{8'h02, 8'h02, 1'b1, 8'h02}, '{8'h01, 8'hFF, 1'b1, 8'h01},
        '{8'hFF, 8'hA5, 1'b1, 8'hA5}, '{8'h00, 8'hFF, 1'b1, 8'h00}};
    ext_irq_ctrl #(.NSRC(8)) dut_u (.REF_CLK(clk), .NRST(nrst),
        .SFR_ADDR(addr), .SFR_WDATA(wdata), .SFR_WE(we), .SFR_RE(re),
        .SFR_RDATA(rdata), .SRC_REQ(src), .GLOBAL_IRQ_ENABLE(glob),
        .PORT0_IN(pins), .EXT_VECTOR_ACK(ack), .IRQ_REQ(irq),
        .IRQ_PRIO(prio), .EXT_PENDING(pend), .EXT_REQ(ereq));
    cpu_vector_model cpu_u (.clk(clk), .rst_n(nrst), .ext_req(ereq),
        .ack_en(ack_en), .slow(slow), .vector_ack(ack));
    // -------------------------------------------------------------
    // clock and helpers
    // -------------------------------------------------------------
    always #2 clk = ~clk;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        we <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
    endtask
    // data lands on the edge that takes the strobe; the task samples it one edge later
    task automatic rdr(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        tick(1);
        rd = rdata;
    endtask
    // bounded wait on one pending flag; running out is a mismatch
    task automatic wait_pend(input int i, input logic v);
        for (int k = 0; k < 30 && pend[i] !== v; k++) tick(1);
        chk({7'h0, pend[i]}, {7'h0, v});
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // -------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------
    initial begin
        {clk, nrst, we, re, glob, ack_en, slow} = 7'h00;
        {addr, wdata, src} = 24'h000000;
        pins = 8'hFF; // port pull-ups hold pins high
        miscompares = 0;
        n_tests = 0;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        rdr(ADDR_ENABLE); chk(rd, 8'h00);
        rdr(ADDR_PRIO); chk(rd, 8'h00);
        rdr(ADDR_EXT_CFG); chk(rd, 8'h01);
        rdr(ADDR_TIMER_CTL); chk(rd, 8'h00);
        rdr(8'h55); chk(rd, RDATA_UNMAPPED);
        foreach (rows[i]) begin
            wr(ADDR_ENABLE, rows[i].en);
            @(posedge clk);
            src <= rows[i].src;
            glob <= rows[i].glob;
            tick(1);
            chk(irq, rows[i].exp);
            rdr(ADDR_ENABLE); chk(rd, rows[i].en);
        end
        wr(ADDR_PRIO, 8'hA5);
        rdr(ADDR_PRIO); chk(rd, 8'hA5);
        chk(prio, 8'hA5);
        // a on pin 2 active high, b on pin 5 active low, level mode
        wr(ADDR_EXT_CFG, 8'h5A);
        tick(4); chk({6'h0, pend}, 8'h01);
        chk({6'h0, ereq}, 8'h01);
        // source held its level, now drops a and raises b
        @(posedge clk);
        pins <= 8'hDB;
        tick(4); chk({6'h0, pend}, 8'h02);
        wr(ADDR_TIMER_CTL, 8'h0A);
        tick(1); chk({6'h0, pend}, 8'h02);
        rdr(ADDR_TIMER_CTL); chk(rd, 8'h08);
        glob <= 1'b0;
        tick(2); chk({6'h0, ereq}, 8'h00);
        glob <= 1'b1;
        // edge mode: pending set by a transition or a software write of one; the switching
        // write lands while still in level mode, so b keeps its flag
        wr(ADDR_TIMER_CTL, 8'h05);
        tick(1); chk({6'h0, pend}, 8'h02);
        // now in edge mode the software write of zero clears it
        wr(ADDR_TIMER_CTL, 8'h05);
        tick(1); chk({6'h0, pend}, 8'h00);
        @(posedge clk);
        pins <= 8'hDF;
        tick(2); chk({6'h0, pend}, 8'h00);
        tick(1); chk({6'h0, pend}, 8'h01);
        slow <= 1'b1;
        ack_en <= 1'b1;
        wait_pend(0, 1'b0);
        tick(8); chk({6'h0, pend}, 8'h00);
        ack_en <= 1'b0;
        @(posedge clk);
        pins <= 8'hFF;
        tick(4);
        pins <= 8'hDF;
        wait_pend(1, 1'b1);
        wr(ADDR_TIMER_CTL, 8'h05);
        tick(1); chk({6'h0, pend}, 8'h00);
        // second reset in mid-run
        @(posedge clk);
        nrst <= 1'b0;
        tick(2); chk({6'h0, pend}, 8'h00);
        nrst <= 1'b1;
        rdr(ADDR_PRIO); chk(rd, 8'h00);
        rdr(ADDR_EXT_CFG); chk(rd, 8'h01);
        conclude();
    end
    // hang guard
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        conclude();
    end
endmodule // tb_top
bind ext_irq_ctrl ext_irq_ctrl_assertions #(.NSRC(NSRC)) chk_u (
    .REF_CLK(REF_CLK), .NRST(NRST), .SFR_ADDR(SFR_ADDR),
    .SFR_WDATA(SFR_WDATA), .SFR_WE(SFR_WE), .SFR_RE(SFR_RE),
    .SFR_RDATA(SFR_RDATA), .SRC_REQ(SRC_REQ),
    .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE), .PORT0_IN(PORT0_IN),
    .EXT_VECTOR_ACK(EXT_VECTOR_ACK), .IRQ_REQ(IRQ_REQ),
    .IRQ_PRIO(IRQ_PRIO), .EXT_PENDING(EXT_PENDING), .EXT_REQ(EXT_REQ));

// ---- core/ext_irq_channel.sv ----
// one external interrupt input: pin select, polarity, edge or level
module ext_irq_channel
    import irq_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic [NUM_PINS-1:0] pins, // synchronised port levels
    input wire ext_cfg_t cfg, // polarity, trigger, pin select
    input wire logic vector_ack, // processor vectors to this routine
    input wire logic sw_we, // software writes the pending bit
    input wire logic sw_val, // value written
    output logic pending // pending flag
);
    logic active;
    logic prev_r;
    logic prev_nxt;
    logic pend_r;
    logic pend_nxt;

    assign active = cfg.polarity ? pins[cfg.pin_select]
                                 : ~pins[cfg.pin_select];

    // hardware set is applied last so it wins over any clear
    always_comb begin
        prev_nxt = active;
        pend_nxt = pend_r;
        if (cfg.trigger_edge) begin
            if (vector_ack) begin
                pend_nxt = 1'b0;
            end
            if (sw_we) begin
                pend_nxt = sw_val;
            end
            if (active && !prev_r) begin
                pend_nxt = 1'b1;
            end
        end else begin
            pend_nxt = active;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_r <= 1'b0;
            pend_r <= 1'b0;
        end else begin
            prev_r <= prev_nxt;
            pend_r <= pend_nxt;
        end
    end

    assign pending = pend_r;
endmodule // ext_irq_channel

// ---- core/ext_irq_ctrl.sv ----
// extended interrupt mask, priority and external pin interrupt unit
module ext_irq_ctrl
    import irq_pkg::*;
#(
    parameter int NSRC = 8
) (
    input wire logic REF_CLK, // system clock, 250 MHz
    input wire logic NRST, // async reset, active low
    input wire logic [7:0] SFR_ADDR, // register address
    input wire logic [7:0] SFR_WDATA, // write data
    input wire logic SFR_WE, // write strobe
    input wire logic SFR_RE, // read strobe
    output logic [7:0] SFR_RDATA, // read data, one clock after strobe
    input wire logic [NSRC-1:0] SRC_REQ, // peripheral requests
    input wire logic GLOBAL_IRQ_ENABLE, // global enable from base regs
    input wire logic [NUM_PINS-1:0] PORT0_IN, // port 0 pin levels
    input wire logic [NUM_EXT-1:0] EXT_VECTOR_ACK, // vector taken
    output logic [NSRC-1:0] IRQ_REQ, // gated requests
    output logic [NSRC-1:0] IRQ_PRIO, // priority per request
    output logic [NUM_EXT-1:0] EXT_PENDING, // external pending flags
    output logic [NUM_EXT-1:0] EXT_REQ // pending and globally enabled
);

    // ----------------------------------------------------------------
    // parameter checks
    // ----------------------------------------------------------------
    // the register map has exactly one bit per source
    generate
        if (NSRC != 8) begin : g_bad_nsrc
            $error("ext_irq_ctrl: NSRC must be 8");
        end
    endgenerate

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    // used by both the write and the read path
    function automatic logic hit(input logic [7:0] a,
                                 input logic [7:0] reg_addr);
        hit = (a == reg_addr);
    endfunction

    logic wr_en;
    logic wr_prio;
    logic wr_cfg;
    logic wr_tctl;

    // write strobes per register
    assign wr_en = SFR_WE && hit(SFR_ADDR, ADDR_ENABLE);
    assign wr_prio = SFR_WE && hit(SFR_ADDR, ADDR_PRIO);
    assign wr_cfg = SFR_WE && hit(SFR_ADDR, ADDR_EXT_CFG);
    assign wr_tctl = SFR_WE && hit(SFR_ADDR, ADDR_TIMER_CTL);

    // ----------------------------------------------------------------
    // software registers
    // ----------------------------------------------------------------
    logic [7:0] enable_r;
    logic [7:0] enable_nxt;
    logic [7:0] prio_r;
    logic [7:0] prio_nxt;
    logic [7:0] cfg_r;
    logic [7:0] cfg_nxt;
    logic [1:0] trig_r;
    logic [1:0] trig_nxt;

    // next values; enable, priority and config writes replace the whole byte, timer control keeps only the two trigger bits
    always_comb begin
        enable_nxt = enable_r;
        prio_nxt = prio_r;
        cfg_nxt = cfg_r;
        trig_nxt = trig_r;
        if (wr_en) begin
            enable_nxt = SFR_WDATA;
        end
        if (wr_prio) begin
            prio_nxt = SFR_WDATA;
        end
        if (wr_cfg) begin
            cfg_nxt = SFR_WDATA;
        end
        if (wr_tctl) begin
            trig_nxt[0] = SFR_WDATA[TCTL_A_TRIG];
            trig_nxt[1] = SFR_WDATA[TCTL_B_TRIG];
        end
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            enable_r <= RST_ENABLE;
            prio_r <= RST_PRIO;
            cfg_r <= RST_EXT_CFG;
            trig_r <= RST_TRIGGER;
        end else begin
            enable_r <= enable_nxt;
            prio_r <= prio_nxt;
            cfg_r <= cfg_nxt;
            trig_r <= trig_nxt;
        end
    end

    // ----------------------------------------------------------------
    // external interrupt inputs
    // ----------------------------------------------------------------
    logic [NUM_PINS-1:0] pins_sync;
    ext_cfg_t ext_cfg [NUM_EXT];
    logic [NUM_EXT-1:0] ext_sw_val;
    logic [NUM_EXT-1:0] ext_pend;

    pin_sync #(
        .WIDTH(NUM_PINS)
    ) u_sync (
        .clk(REF_CLK),
        .rst_n(NRST),
        .async_in(PORT0_IN),
        .sync_out(pins_sync)
    );

    // unpack config fields per input
    assign ext_cfg[0].polarity = cfg_r[CFG_A_POL];
    assign ext_cfg[0].trigger_edge = trig_r[0];
    assign ext_cfg[0].pin_select = cfg_r[CFG_A_SEL_LSB +: SEL_W];
    assign ext_cfg[1].polarity = cfg_r[CFG_B_POL];
    assign ext_cfg[1].trigger_edge = trig_r[1];
    assign ext_cfg[1].pin_select = cfg_r[CFG_B_SEL_LSB +: SEL_W];
    assign ext_sw_val[0] = SFR_WDATA[TCTL_A_PEND];
    assign ext_sw_val[1] = SFR_WDATA[TCTL_B_PEND];

    // both inputs are the same logic with their own fields
    generate
        for (genvar i = 0; i < NUM_EXT; i++) begin : g_ext
            ext_irq_channel u_chan (
                .clk(REF_CLK),
                .rst_n(NRST),
                .pins(pins_sync),
                .cfg(ext_cfg[i]),
                .vector_ack(EXT_VECTOR_ACK[i]),
                .sw_we(wr_tctl),
                .sw_val(ext_sw_val[i]),
                .pending(ext_pend[i])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // request gating
    // ----------------------------------------------------------------
    logic [NSRC-1:0] gated;
    logic [NSRC-1:0] req_r;
    logic [NSRC-1:0] req_nxt;
    logic [NSRC-1:0] prio_out_r;
    logic [NSRC-1:0] prio_out_nxt;
    logic [NUM_EXT-1:0] ext_req_r;
    logic [NUM_EXT-1:0] ext_req_nxt;

    assign gated[BIT_PORT_MATCH] =
        SRC_REQ[BIT_PORT_MATCH] & enable_r[BIT_PORT_MATCH];
    assign gated[BIT_REG_DROP] =
        SRC_REQ[BIT_REG_DROP] & enable_r[BIT_REG_DROP];
    assign gated[BIT_LIN] = SRC_REQ[BIT_LIN] & enable_r[BIT_LIN];
    assign gated[BIT_CMP_RISE] =
        SRC_REQ[BIT_CMP_RISE] & enable_r[BIT_CMP_RISE];
    assign gated[BIT_CMP_FALL] =
        SRC_REQ[BIT_CMP_FALL] & enable_r[BIT_CMP_FALL];
    assign gated[BIT_COUNTER] =
        SRC_REQ[BIT_COUNTER] & enable_r[BIT_COUNTER];
    assign gated[BIT_CONV_DONE] =
        SRC_REQ[BIT_CONV_DONE] & enable_r[BIT_CONV_DONE];
    assign gated[BIT_WINDOW] =
        SRC_REQ[BIT_WINDOW] & enable_r[BIT_WINDOW];

    // the global enable is applied last so it overrides every mask
    always_comb begin
        req_nxt = GLOBAL_IRQ_ENABLE ? gated : '0;
        prio_out_nxt = prio_r;
        ext_req_nxt = GLOBAL_IRQ_ENABLE ? ext_pend : '0;
    end

    // outputs from flops; one clock later than the source
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            req_r <= '0;
            prio_out_r <= '0;
            ext_req_r <= '0;
        end else begin
            req_r <= req_nxt;
            prio_out_r <= prio_out_nxt;
            ext_req_r <= ext_req_nxt;
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic [7:0] tctl_view;

    // pending flags at bits 1 and 3
    always_comb begin
        tctl_view = 8'h00;
        tctl_view[TCTL_A_TRIG] = trig_r[0];
        tctl_view[TCTL_A_PEND] = ext_pend[0];
        tctl_view[TCTL_B_TRIG] = trig_r[1];
        tctl_view[TCTL_B_PEND] = ext_pend[1];
    end

    // unmapped addresses read as zero; data holds between reads
    always_comb begin
        rdata_nxt = rdata_r;
        if (SFR_RE) begin
            if (hit(SFR_ADDR, ADDR_ENABLE)) begin
                rdata_nxt = enable_r;
            end else if (hit(SFR_ADDR, ADDR_PRIO)) begin
                rdata_nxt = prio_r;
            end else if (hit(SFR_ADDR, ADDR_EXT_CFG)) begin
                rdata_nxt = cfg_r;
            end else if (hit(SFR_ADDR, ADDR_TIMER_CTL)) begin
                rdata_nxt = tctl_view;
            end else begin
                rdata_nxt = RDATA_UNMAPPED;
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // level source must drop before the routine ends, else the
    // pending flag simply stays up and requests again
    assign SFR_RDATA = rdata_r;
    assign IRQ_REQ = req_r;
    assign IRQ_PRIO = prio_out_r;
    assign EXT_PENDING = ext_pend;
    assign EXT_REQ = ext_req_r;

endmodule // ext_irq_ctrl

// ---- core/irq_pkg.sv ----
// constants and types for the extended interrupt mask and external pins
package irq_pkg;

    // ----------------------------------------------------------------
    // register addresses and reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_ENABLE = 8'hE6;
    localparam logic [7:0] ADDR_PRIO = 8'hF6;
    localparam logic [7:0] ADDR_EXT_CFG = 8'hE4;
    localparam logic [7:0] ADDR_TIMER_CTL = 8'h88;
    localparam logic [7:0] RST_ENABLE = 8'h00;
    localparam logic [7:0] RST_PRIO = 8'h00;
    localparam logic [7:0] RST_EXT_CFG = 8'h01;
    localparam logic [1:0] RST_TRIGGER = 2'h0;
    localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int BIT_PORT_MATCH = 7;
    localparam int BIT_REG_DROP = 6;
    localparam int BIT_LIN = 5;
    localparam int BIT_CMP_RISE = 4;
    localparam int BIT_CMP_FALL = 3;
    localparam int BIT_COUNTER = 2;
    localparam int BIT_CONV_DONE = 1;
    localparam int BIT_WINDOW = 0;
    localparam int TCTL_A_TRIG = 0;
    localparam int TCTL_A_PEND = 1;
    localparam int TCTL_B_TRIG = 2;
    localparam int TCTL_B_PEND = 3;
    localparam int CFG_A_SEL_LSB = 0;
    localparam int CFG_A_POL = 3;
    localparam int CFG_B_SEL_LSB = 4;
    localparam int CFG_B_POL = 7;
    localparam int SEL_W = 3;
    localparam int NUM_EXT = 2;
    localparam int NUM_PINS = 8;

    // one external input's setup
    typedef struct packed {
        logic polarity;
        logic trigger_edge;
        logic [SEL_W-1:0] pin_select;
    } ext_cfg_t;

endpackage : irq_pkg

// ---- core/pin_sync.sv ----
// two-flop synchroniser for the monitored port pins
module pin_sync
    import irq_pkg::*;
#(
    parameter int WIDTH = NUM_PINS
) (
    input wire logic clk, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic [WIDTH-1:0] async_in, // raw pin levels
    output logic [WIDTH-1:0] sync_out // levels in clock domain
);
    generate
        if (WIDTH < 1) begin : g_bad_width
            $error("pin_sync: WIDTH must be at least one");
        end
    endgenerate

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] meta_nxt;
    logic [WIDTH-1:0] sync_r;
    logic [WIDTH-1:0] sync_nxt;

    // first stage is read by the second stage only
    always_comb begin
        meta_nxt = async_in;
        sync_nxt = meta_r;
    end

    // pins idle high with pullups, but reset must load a constant
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign sync_out = sync_r;
endmodule // pin_sync
